// [rtl/fbctl_pkg.sv]
// package: constants, types and register map of the flash bus controller
package fbctl_pkg;

  // ---------------------------------------------------------------
  // clock and pin timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_SETUP_NS = 8;
  localparam int T_READ_NS = 80;
  localparam int T_WPULSE_NS = 40;
  localparam int T_WHIGH_NS = 24;
  localparam int T_RPULSE_NS = 500;
  localparam int T_RHOLD_NS = 200;
  // least times round up to whole cycles
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPULSE_CYC = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WHIGH_CYC = (T_WHIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RPULSE_CYC = (T_RPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RHOLD_CYC = (T_RHOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LAT = 3;
  localparam int CNT_W = 8;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int DQ_W = 16;
  localparam int BYTE_W = 8;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_PRE = 8'h0c;
  localparam logic [7:0] REG_GO = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RDATA = 8'h18;

  // ctrl fields
  localparam int CTRL_WIDTH_BIT = 0;
  localparam int CTRL_PROT_BIT = 1;
  localparam int CTRL_ACCEL_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  typedef enum logic [2:0] {
    FBCTL_OP_READ = 3'h0,
    FBCTL_OP_WRITE = 3'h1,
    FBCTL_OP_WRITE2 = 3'h2,
    FBCTL_OP_RESET = 3'h3
  } fbctl_op_t;

  typedef enum logic [2:0] {
    FBCTL_ST_IDLE = 3'h0,
    FBCTL_ST_SETUP = 3'h1,
    FBCTL_ST_STROBE = 3'h2,
    FBCTL_ST_HOLD = 3'h3,
    FBCTL_ST_RST = 3'h4,
    FBCTL_ST_RREC = 3'h5
  } fbctl_st_t;

  // flash pins as driven by the controller
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_out;
    logic [DQ_W-1:0] dq_oe;
    logic flash_width_select;
    logic protect_accel_pin;
    logic protect_accel_vhh;
    logic sram_select1_n;
    logic sram_select2;
  } fbctl_pins_t;

endpackage

// [rtl/fbctl_sync.sv]
// three-stage synchroniser for the flash data pins
`timescale 1ns/1ps
module fbctl_sync #(
  parameter int W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  // ---------------------------------------------------------------
  // stages; a bit moves out only when stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign dout = out_q;
endmodule

// [rtl/fbctl_top.sv]
// flash bus controller: ahb-lite registers in, flash pin cycles out
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps

module fbctl_top
  import fbctl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [DQ_W-1:0] flash_dq_in,
  output fbctl_pins_t flash_pins
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata_bus;
    logic [2:0] ctrl;
    logic [ADDR_W:0] addr;
    logic [DQ_W-1:0] wdata;
    logic [DQ_W-1:0] pre;
    logic [DQ_W-1:0] rdata;
    logic done;
    fbctl_op_t op;
    fbctl_st_t st;
    logic phase;
    logic [CNT_W-1:0] cnt;
    fbctl_pins_t pins;
  } fbctl_state_t;

  fbctl_state_t s_q;
  fbctl_state_t s_d;
  logic [DQ_W-1:0] dq_sync;
  logic busy;

  fbctl_sync #(
    .W(DQ_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(flash_dq_in),
    .dout(dq_sync)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a, input fbctl_state_t s,
                                           input logic b);
    reg_read = 32'h0000_0000;
    case (a)
      REG_CTRL: reg_read = {29'h0, s.ctrl};
      REG_ADDR: reg_read = {{(31 - ADDR_W){1'b0}}, s.addr};
      REG_WDATA: reg_read = {16'h0000, s.wdata};
      REG_PRE: reg_read = {16'h0000, s.pre};
      REG_STATUS: reg_read = {30'h0, s.done, b};
      REG_RDATA: reg_read = {16'h0000, s.rdata};
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  // pins as a function of the next state
  function automatic fbctl_pins_t drive(input fbctl_state_t s);
    logic wide;
    logic wr;
    logic [DQ_W-1:0] data;
    wide = s.ctrl[CTRL_WIDTH_BIT];
    wr = (s.op != FBCTL_OP_READ);
    data = (s.op == FBCTL_OP_WRITE2 && !s.phase) ? s.pre : s.wdata;
    drive.ce_n = 1'b1;
    drive.oe_n = 1'b1;
    drive.we_n = 1'b1;
    drive.rst_n = !(s.st == FBCTL_ST_RST);
    drive.flash_width_select = wide;
    drive.sram_select1_n = 1'b1;
    drive.sram_select2 = 1'b0;
    // pin always driven; high voltage only inside accelerated program
    drive.protect_accel_pin = s.ctrl[CTRL_PROT_BIT];
    drive.protect_accel_vhh = s.ctrl[CTRL_ACCEL_BIT] && s.op == FBCTL_OP_WRITE2 &&
                              s.st != FBCTL_ST_IDLE && s.st != FBCTL_ST_RST &&
                              s.st != FBCTL_ST_RREC;
    // word mode: address is addr[20:0]; byte mode: addr[21:1], addr[0] on dq15
    drive.addr = wide ? s.addr[ADDR_W-1:0] : s.addr[ADDR_W:1];
    drive.dq_out = '0;
    drive.dq_oe = '0;
    if (!wide) begin
      drive.dq_out[DQ_W-1] = s.addr[0];
      drive.dq_oe[DQ_W-1] = 1'b1;
    end
    if (s.st == FBCTL_ST_SETUP || s.st == FBCTL_ST_STROBE) begin
      drive.ce_n = 1'b0;
      if (s.st == FBCTL_ST_STROBE) begin
        drive.oe_n = wr;
        drive.we_n = !wr;
      end
    end
    if (wr && (s.st == FBCTL_ST_SETUP || s.st == FBCTL_ST_STROBE ||
               s.st == FBCTL_ST_HOLD)) begin
      if (wide) begin
        drive.dq_out = data;
        drive.dq_oe = '1;
      end else begin
        drive.dq_out[BYTE_W-1:0] = data[BYTE_W-1:0];
        drive.dq_oe[BYTE_W-1:0] = '1;
      end
    end
  endfunction

  assign busy = (s_q.st != FBCTL_ST_IDLE);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // ahb: zero-wait slave, read data registered in the address phase
    s_d.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_d.wr_pend = hwrite;
      s_d.wr_addr = haddr[7:0];
      if (!hwrite) begin
        s_d.rdata_bus = reg_read(haddr[7:0], s_q, busy);
      end
    end
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        REG_CTRL: s_d.ctrl = hwdata[2:0];
        REG_ADDR: s_d.addr = hwdata[ADDR_W:0];
        REG_WDATA: s_d.wdata = hwdata[DQ_W-1:0];
        REG_PRE: s_d.pre = hwdata[DQ_W-1:0];
        REG_STATUS: begin
          if (hwdata[STAT_DONE_BIT]) begin
            s_d.done = 1'b0;
          end
        end
        REG_GO: begin
          // start ignored while a cycle runs; undefined codes do nothing
          if (!busy && hwdata[2:0] <= 3'(FBCTL_OP_RESET)) begin
            s_d.op = fbctl_op_t'(hwdata[2:0]);
            s_d.phase = 1'b0;
            s_d.done = 1'b0;
            if (hwdata[2:0] == 3'(FBCTL_OP_RESET)) begin
              s_d.st = FBCTL_ST_RST;
              s_d.cnt = cyc(RPULSE_CYC);
            end else begin
              s_d.st = FBCTL_ST_SETUP;
              s_d.cnt = cyc(SETUP_CYC);
            end
          end
        end
        default: ;
      endcase
    end

    // flash cycle sequencer
    case (s_q.st)
      FBCTL_ST_IDLE: ;
      FBCTL_ST_SETUP: begin
        if (s_q.cnt == '0) begin
          s_d.st = FBCTL_ST_STROBE;
          // read waits out access time plus synchroniser latency
          s_d.cnt = (s_q.op == FBCTL_OP_READ) ? cyc(READ_CYC + SYNC_LAT) : cyc(WPULSE_CYC);
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      FBCTL_ST_STROBE: begin
        if (s_q.cnt == '0) begin
          if (s_q.op == FBCTL_OP_READ) begin
            // byte mode keeps only the low byte
            s_d.rdata = s_q.ctrl[CTRL_WIDTH_BIT] ? dq_sync :
                        {8'h00, dq_sync[BYTE_W-1:0]};
          end
          s_d.st = FBCTL_ST_HOLD;
          s_d.cnt = cyc(WHIGH_CYC);
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      FBCTL_ST_HOLD: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else if (s_q.op == FBCTL_OP_WRITE2 && !s_q.phase) begin
          // second write of the two-cycle program
          s_d.phase = 1'b1;
          s_d.st = FBCTL_ST_SETUP;
          s_d.cnt = cyc(SETUP_CYC);
        end else begin
          s_d.st = FBCTL_ST_IDLE;
          s_d.done = 1'b1;
        end
      end
      FBCTL_ST_RST: begin
        if (s_q.cnt == '0) begin
          s_d.st = FBCTL_ST_RREC;
          s_d.cnt = cyc(RHOLD_CYC);
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      FBCTL_ST_RREC: begin
        if (s_q.cnt == '0) begin
          s_d.st = FBCTL_ST_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      default: s_d.st = FBCTL_ST_IDLE;
    endcase

    s_d.pins = drive(s_d);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.st <= FBCTL_ST_IDLE;
      s_q.op <= FBCTL_OP_READ;
      s_q.pins.ce_n <= 1'b1;
      s_q.pins.oe_n <= 1'b1;
      s_q.pins.we_n <= 1'b1;
      s_q.pins.rst_n <= 1'b1;
      s_q.pins.flash_width_select <= 1'b1;
      s_q.pins.sram_select1_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata_bus;
  assign flash_pins = s_q.pins;

endmodule

// [tb/fbctl_top_asserts.sv]
// checker on the flash pins driven by the controller
`timescale 1ns/1ps
module fbctl_top_asserts
  import fbctl_pkg::*;
(
  input logic hclk,
  input logic hresetn,
  input fbctl_pins_t flash_pins
);
  fbctl_pins_t p;
  assign p = flash_pins;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ------
  // pin cycles
  // ------
  read_strobe_a: assert property (!p.oe_n |-> !p.ce_n && p.we_n)
    else $error("oe low outside a read");
  read_length_a: assert property ($fell(p.oe_n) |-> ##12 !p.oe_n ##1 p.oe_n)
    else $error("read strobe length wrong");
  read_float_a: assert property (!p.oe_n |-> p.dq_oe == {!p.flash_width_select, 15'h0})
    else $error("data driven during read");
  write_strobe_a: assert property (!p.we_n |-> !p.ce_n && p.oe_n && p.dq_oe[7:0] == 8'hff)
    else $error("we low outside a write");
  write_length_a: assert property ($fell(p.we_n) |-> !p.we_n [*5] ##1 p.we_n)
    else $error("write strobe length wrong");
  accel_pair_a: assert property ($rose(p.protect_accel_vhh) |->
    ##[0:2] $fell(p.we_n) ##[8:10] $fell(p.we_n))
    else $error("accelerated op not two writes");
  accel_only_a: assert property (p.protect_accel_vhh |-> p.oe_n && p.rst_n)
    else $error("high voltage outside programming");
  reset_width_a: assert property ($fell(p.rst_n) |-> ##62 !p.rst_n ##1 p.rst_n)
    else $error("reset pulse width wrong");
  sram_off_a: assert property (p.sram_select1_n && !p.sram_select2)
    else $error("sram selected");
endmodule

bind fbctl_top fbctl_top_asserts fbctl_top_asserts_inst (
  .hclk(hclk),
  .hresetn(hresetn),
  .flash_pins(flash_pins)
);

// [tb/fbctl_flash_model.sv]
// behavioural flash device at the far end of the pins
`timescale 1ns/1ps
module fbctl_flash_model
  import fbctl_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h3c // arbitrary value
) (
  input fbctl_pins_t p,
  output logic [DQ_W-1:0] dq
);
  logic [15:0] mem [int];
  logic [15:0] flip = 16'h5a5a;
  logic [15:0] v;
  logic [15:0] d;
  logic auto_q = 1'b0;
  logic byp_q = 1'b0;
  logic prog_q = 1'b0;
  logic ers_q = 1'b0;
  logic fast_q = 1'b0;
  int seq = 0;

  function automatic logic [15:0] arr(input int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction

  // outermost two boot sectors, unless the protect pin lifts them
  function automatic logic locked(input logic [20:0] a);
    return !p.protect_accel_pin && !p.protect_accel_vhh && a[20:13] == 8'hff;
  endfunction

  // small boot sectors on top, large code sectors below
  function automatic logic [8:0] sect(input logic [20:0] a);
    return (a[20:15] == 6'h3f) ? a[20:12] : {a[20:15], 3'h0};
  endfunction

  // one sector or the whole array, protected sectors kept
  task automatic erase(input logic [20:0] a, input logic all);
    int ks[$];
    foreach (mem[k])
      if ((all || sect(21'(k)) == sect(a)) && !locked(21'(k)))
        ks.push_back(k);
    foreach (ks[i])
      mem.delete(ks[i]);
  endtask

  // ------
  // command decode, reset and outputs
  // ------
  always @(negedge p.we_n) begin
    d = p.dq_out;
    if (!p.ce_n && p.oe_n && p.rst_n) begin
      if (prog_q) begin
        prog_q = 1'b0;
        // program ran on the shortened accelerated time
        fast_q = p.protect_accel_vhh;
        if (!locked(p.addr))
          mem[p.addr] = arr(p.addr) & d;
      end else if (ers_q && d == 16'h30)
        erase(p.addr, 1'b0);
      else if (d == 16'hf0)
        auto_q = 1'b0;
      else if ((byp_q || p.protect_accel_vhh) && d == 16'ha0)
        prog_q = 1'b1;
      else if (seq < 2) begin
        ers_q = 1'b0;
        seq = (d == (seq == 0 ? 16'haa : 16'h55)) ? seq + 1 : 0;
      end else begin
        auto_q = (d == 16'h90);
        byp_q = byp_q || (d == 16'h20);
        prog_q = (d == 16'ha0);
        // further sector codes add sectors to the erase
        ers_q = (d == 16'h30);
        if (d == 16'h30 || d == 16'h10)
          erase(p.addr, d == 16'h10);
        seq = 0;
      end
    end
  end

  always @(negedge p.rst_n) begin
    auto_q = 1'b0;
    ers_q = 1'b0;
    byp_q = 1'b0;
    prog_q = 1'b0;
    seq = 0;
  end

  // released lines show a toggling pattern
  always begin
    flip = ~flip;
    v = auto_q ? {8'h00, ID_CODE} : arr(p.addr);
    if (p.ce_n || p.oe_n || !p.rst_n)
      dq = flip;
    else if (p.flash_width_select)
      dq = v;
    else
      dq = {flip[15:8], p.dq_out[15] ? v[15:8] : v[7:0]};
    #4;
  end
endmodule

// [tb/tb.sv]
// self-checking bench with ahb-lite master and reference memory
`timescale 1ns/1ps
module tb
  import fbctl_pkg::*;
();
  localparam logic [7:0] ID_CODE = 8'h3c; // arbitrary value
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [DQ_W-1:0] dq_m, flash_dq_in;
  fbctl_pins_t flash_pins;
  int fails = 0;
  int total_checks = 0;
  int ref_mem [int];

  assign flash_dq_in = (flash_pins.dq_oe & flash_pins.dq_out) | (~flash_pins.dq_oe & dq_m);

  fbctl_top fbctl_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_dq_in(flash_dq_in),
    .flash_pins(flash_pins));
  fbctl_flash_model #(.ID_CODE(ID_CODE)) fbctl_flash_model_inst (.p(flash_pins), .dq(dq_m));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ------
  // bus, flash and compare tasks
  // ------
  task end_sim;
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task op(input logic [2:0] code);
    logic [31:0] s;
    wr(REG_GO, {29'h0, code});
    @(posedge hclk);
    ahb(1'b0, REG_STATUS, 32'h0, s);
    chk({31'h0, s[STAT_BUSY_BIT]}, 32'h1);
    // polls status until the done bit is set
    while (s[STAT_DONE_BIT] !== 1'b1)
      ahb(1'b0, REG_STATUS, 32'h0, s);
  endtask

  // code 1 writes data once, code 2 writes a0 then data
  task fwr(input logic [20:0] a, input logic [15:0] d, input logic [2:0] code);
    wr(REG_ADDR, {11'h0, a});
    wr(REG_PRE, 32'h00a0);
    wr(REG_WDATA, {16'h0, d});
    op(code);
  endtask

  task frd(input logic [21:0] a, input logic [15:0] e);
    logic [31:0] r;
    wr(REG_ADDR, {10'h0, a});
    op(3'h0);
    ahb(1'b0, REG_RDATA, 32'h0, r);
    chk(r, {16'h0, e});
  endtask

  task unl(input logic [15:0] c);
    fwr(21'h555, 16'haa, 3'h1);
    fwr(21'h2aa, 16'h55, 3'h1);
    fwr(21'h555, c, 3'h1);
  endtask

  function automatic logic [15:0] exp_rd(input int a);
    return ref_mem.exists(a) ? 16'(ref_mem[a]) : 16'hffff;
  endfunction

  initial begin
    #200000;
    fails++;
    $display("[ERR] %0t timeout", $time);
    end_sim;
  end

  initial begin
    logic [20:0] a, b, bt;
    logic [15:0] d;
    logic [31:0] r;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    void'($urandom(32'hceaf));
    a = 21'($urandom) & 21'h0fffff;
    b = a ^ 21'h000100;
    bt = {8'hff, 13'($urandom)};
    d = 16'($urandom);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    r = {29'h0, flash_pins.ce_n, flash_pins.rst_n, flash_pins.flash_width_select};
    chk(r, 32'h7);
    ahb(1'b0, REG_CTRL, 32'h0, r);
    chk(r, {29'h0, CTRL_RESET});
    ahb(1'b0, 8'h1c, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    frd({1'b0, a}, exp_rd(a));
    unl(16'ha0);
    fwr(a, d, 3'h1);
    ref_mem[a] = exp_rd(a) & d;
    frd({1'b0, a}, exp_rd(a));
    unl(16'h20);
    d = 16'($urandom);
    fwr(b, d, 3'h2);
    ref_mem[b] = exp_rd(b) & d;
    chk({31'h0, fbctl_flash_model_inst.fast_q}, 32'h0);
    frd({1'b0, b}, exp_rd(b));
    fwr(bt, d, 3'h2);
    frd({1'b0, bt}, exp_rd(bt));
    wr(REG_CTRL, 32'h5);
    fwr(bt, d, 3'h2);
    ref_mem[bt] = exp_rd(bt) & d;
    chk({31'h0, fbctl_flash_model_inst.fast_q}, 32'h1);
    wr(REG_CTRL, 32'h1);
    frd({1'b0, bt}, exp_rd(bt));
    op(3'h3);
    fwr(b ^ 21'h1, 16'h0, 3'h2);
    frd({1'b0, b ^ 21'h1}, exp_rd(b ^ 21'h1));
    unl(16'h90);
    frd({1'b0, a}, {8'h0, ID_CODE});
    fwr(21'h0, 16'hf0, 3'h1);
    frd({1'b0, a}, exp_rd(a));
    wr(REG_CTRL, 32'h0);
    d = exp_rd(a);
    frd({a, 1'b1}, {8'h0, d[15:8]});
    frd({a, 1'b0}, {8'h0, d[7:0]});
    // sector erase: a and b share one code sector
    wr(REG_CTRL, 32'h1);
    fwr(21'h555, 16'haa, 3'h1);
    fwr(21'h2aa, 16'h55, 3'h1);
    fwr(b, 16'h30, 3'h1);
    ref_mem.delete(a);
    ref_mem.delete(b);
    frd({1'b0, a}, exp_rd(a));
    frd({1'b0, bt}, exp_rd(bt));
    // chip erase with the boot sectors unlocked
    wr(REG_CTRL, 32'h3);
    unl(16'h10);
    wr(REG_CTRL, 32'h1);
    ref_mem.delete();
    frd({1'b0, bt}, exp_rd(bt));
    // undefined start code refused, done kept until cleared
    wr(REG_GO, 32'h7);
    ahb(1'b0, REG_STATUS, 32'h0, r);
    chk(r, 32'h2);
    wr(REG_STATUS, 32'h2);
    ahb(1'b0, REG_STATUS, 32'h0, r);
    chk(r, 32'h0);
    end_sim;
  end
endmodule
